/* File: design/nvacc_pkg.sv */
// package: register map, field positions and timing for the nv storage block
package nvacc_pkg;
    // register word indices (byte address is index * 4)
    localparam logic [7:0] NV_DATA_IDX = 8'h08;
    localparam logic [7:0] NV_ADDR_IDX = 8'h09;
    localparam logic [7:0] NV_CTRL_IDX = 8'h88;
    localparam logic [7:0] NV_UNLOCK_IDX = 8'h89;
    localparam logic [7:0] NV_IRQCTL_IDX = 8'h8b;
    localparam logic [7:0] NV_RESET_IDX = 8'h8c;
    localparam int ADDR_W = 10;
    // storage geometry
    localparam int NV_DEPTH = 64;
    localparam int NV_AW = 6;
    // control register bit positions
    localparam int CTRL_FETCH_BIT = 0;
    localparam int CTRL_PROG_BIT = 1;
    localparam int CTRL_UNLOCK_EN_BIT = 2;
    localparam int CTRL_ABORT_BIT = 3;
    localparam int CTRL_DONE_BIT = 4;
    // interrupt control bit positions
    localparam int IRQ_DONE_EN_BIT = 6;
    localparam int IRQ_GLOBAL_EN_BIT = 7;
    // reset-cause register bit positions (write one to raise)
    localparam int RST_MASTER_CLEAR_PIN_BIT = 0;
    localparam int RST_WDT_BIT = 1;
    // unlock key bytes
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
    // write cycle time
    localparam int WRITE_TIME_US = 4;
    localparam int CLK_MHZ = 125;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
    // erase phase is the first part of the cycle
    localparam int ERASE_CYCLES = WRITE_CYCLES / 2;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // unlock sequence tracker
    typedef enum logic [1:0] {
        UNLK_IDLE,
        UNLK_GOT1,
        UNLK_ARMED
    } nvacc_unlk_t;

    // write cycle state
    typedef enum logic [1:0] {
        WR_IDLE,
        WR_ERASE,
        WR_PROGRAM
    } nvacc_wr_t;

    // axi-lite slave side outputs
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } nvacc_axi_out_t;
endpackage : nvacc_pkg

/* File: design/nvacc_top.sv */
// nonvolatile byte storage access controller with axi4-lite registers
// How it works
// - 64 bytes of storage, addresses 0h to 3Fh via the address register.
// - data register holds the byte; address register the location.
// - a byte write erases the location, then programs the new byte.
// - an internal timer sets the write cycle length.
// - cpu access works regardless of code protection; programmer is blocked.
// - setting fetch_go loads the addressed byte into data next cycle.
// - data register keeps the read byte until next read or sw write.
// - fetch_go self-clears; writing zero to it does nothing.
// - program_go set-only by software, cleared by hardware at the end.
// - write starts only after 55h then AAh to unlock, then program_go.
// - program_go cannot be set while program_unlock_enable is clear.
// - hardware never clears program_unlock_enable.
// - clearing program_unlock_enable mid-write does not affect the write.
// - completion clears program_go and sets a sticky done flag.
// - abort flag sets when master clear or watchdog reset cuts a write.
// - control bits 7 to 5 read as zero.
// - unlock port has no storage; reads return zero.
// - done irq reaches cpu only with its enable and global enable set.
`timescale 1ns/1ns
module nvacc_top
    import nvacc_pkg::*;
#(
    parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // code protection and external programmer port
    input wire logic code_protect,
    input wire logic prog_rd_en,
    input wire logic [NV_AW-1:0] prog_addr,
    output logic [7:0] prog_rdata,
    // status
    output logic write_busy,
    output logic nv_done_irq
);

    ////////////////////////////////////////////////////////////////////
    // storage and state
    logic [7:0] mem [NV_DEPTH];
    logic [7:0] nv_data_reg;
    logic [7:0] nv_addr_reg;
    logic fetch_go_reg;
    logic program_go_reg;
    logic program_unlock_enable_reg;
    logic nv_abort_flag_reg;
    logic nv_done_flag_reg;
    logic nv_done_irq_enable_reg;
    logic global_irq_enable_reg;
    nvacc_unlk_t unlk_reg;
    nvacc_wr_t wr_reg;
    logic [31:0] timer_reg;
    logic [NV_AW-1:0] wr_addr_reg;
    logic [7:0] wr_byte_reg;
    nvacc_axi_out_t axo;
    // registered answer fields, packed into axo by one driver
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    ////////////////////////////////////////////////////////////////////
    // axi write channel: take address and data in either order
    logic aw_held_reg;
    logic w_held_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic wr_fire;
    logic [7:0] wr_idx;
    logic wr_ok;
    logic [7:0] wbyte;

    // whole carrier in one assignment so no field has two drivers
    assign axo = '{awready: !aw_held_reg && !bvalid_reg,
        wready: !w_held_reg && !bvalid_reg, bvalid: bvalid_reg,
        bresp: bresp_reg, arready: !rvalid_reg, rvalid: rvalid_reg,
        rdata: rdata_reg, rresp: rresp_reg};
    assign wr_fire = aw_held_reg && w_held_reg && !axo.bvalid;
    assign wr_idx = aw_addr_reg[9:2];
    assign wr_ok = (aw_addr_reg[1:0] == 2'b00);
    // only lane 0 carries register data; other lanes are dropped
    assign wbyte = w_data_reg[7:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && axo.awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && axo.wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_ok && (wr_idx == NV_DATA_IDX
                    || wr_idx == NV_ADDR_IDX || wr_idx == NV_CTRL_IDX
                    || wr_idx == NV_UNLOCK_IDX || wr_idx == NV_IRQCTL_IDX
                    || wr_idx == NV_RESET_IDX) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // decoded one-cycle register write strobes
    logic we_data, we_addr, we_ctrl, we_unlock, we_irq, we_rst;
    logic lane0;
    assign lane0 = wr_fire && wr_ok && w_strb_reg[0];
    assign we_data = lane0 && wr_idx == NV_DATA_IDX;
    assign we_addr = lane0 && wr_idx == NV_ADDR_IDX;
    assign we_ctrl = lane0 && wr_idx == NV_CTRL_IDX;
    assign we_unlock = lane0 && wr_idx == NV_UNLOCK_IDX;
    assign we_irq = lane0 && wr_idx == NV_IRQCTL_IDX;
    assign we_rst = lane0 && wr_idx == NV_RESET_IDX;

    ////////////////////////////////////////////////////////////////////
    // reset-cause events (master clear / watchdog) raised by software
    logic ext_reset;
    assign ext_reset = we_rst
        && (wbyte[RST_MASTER_CLEAR_PIN_BIT] || wbyte[RST_WDT_BIT]);

    ////////////////////////////////////////////////////////////////////
    // unlock sequence tracker; any other write to the port breaks it
    logic prog_start;
    assign prog_start = we_ctrl && wbyte[CTRL_PROG_BIT]
        && !program_go_reg && program_unlock_enable_reg
        && unlk_reg == UNLK_ARMED;

    always_ff @(posedge aclk) begin
        if (!aresetn || ext_reset) begin
            unlk_reg <= UNLK_IDLE;
        end else if (we_unlock) begin
            // unlock port keeps no value, only sequence position
            if (wbyte == UNLOCK_KEY1) begin
                unlk_reg <= UNLK_GOT1;
            end else if (wbyte == UNLOCK_KEY2 && unlk_reg == UNLK_GOT1) begin
                unlk_reg <= UNLK_ARMED;
            end else begin
                unlk_reg <= UNLK_IDLE;
            end
        end else if (we_ctrl && wbyte[CTRL_PROG_BIT]) begin
            unlk_reg <= UNLK_IDLE; // one byte per sequence
        end else if (lane0) begin
            unlk_reg <= UNLK_IDLE; // any other lane 0 register write breaks the order
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            program_unlock_enable_reg <= 1'b0;
            nv_done_flag_reg <= 1'b0;
        end else begin
            if (we_ctrl) begin
                // only software moves the enable
                program_unlock_enable_reg <= wbyte[CTRL_UNLOCK_EN_BIT];
            end
            if (wr_reg == WR_PROGRAM && timer_reg == 32'd0) begin
                nv_done_flag_reg <= 1'b1;
            end else if (we_ctrl) begin
                nv_done_flag_reg <= wbyte[CTRL_DONE_BIT];
            end
        end
    end

    // abort flag survives external resets; set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nv_abort_flag_reg <= 1'b0;
        end else if (ext_reset && wr_reg != WR_IDLE) begin
            nv_abort_flag_reg <= 1'b1;
        end else if (we_ctrl) begin
            nv_abort_flag_reg <= wbyte[CTRL_ABORT_BIT];
        end
    end

    // fetch_go: set-only, cleared by hardware after one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn || ext_reset) begin
            fetch_go_reg <= 1'b0;
        end else begin
            fetch_go_reg <= we_ctrl && wbyte[CTRL_FETCH_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // data and address registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nv_addr_reg <= '0;
        end else if (we_addr) begin
            nv_addr_reg <= wbyte;
        end
    end

    // read loads data on the very next cycle after the control write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nv_data_reg <= '0;
        end else if (we_ctrl && wbyte[CTRL_FETCH_BIT]) begin
            nv_data_reg <= mem[nv_addr_reg[NV_AW-1:0]];
        end else if (we_data) begin
            nv_data_reg <= wbyte;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // write cycle engine: erase phase then program phase, own timer
    always_ff @(posedge aclk) begin
        if (!aresetn || ext_reset) begin
            wr_reg <= WR_IDLE;
            program_go_reg <= 1'b0;
            timer_reg <= '0;
            wr_addr_reg <= '0;
            wr_byte_reg <= '0;
        end else begin
            case (wr_reg)
                WR_IDLE: begin
                    if (prog_start) begin
                        // latch operands so later changes do not alter it
                        wr_addr_reg <= nv_addr_reg[NV_AW-1:0];
                        wr_byte_reg <= nv_data_reg;
                        program_go_reg <= 1'b1;
                        timer_reg <= 32'(WRITE_CYCLES_P / 2 - 1);
                        wr_reg <= WR_ERASE;
                    end
                end
                WR_ERASE: begin
                    if (timer_reg == 32'd0) begin
                        timer_reg <= 32'(WRITE_CYCLES_P - WRITE_CYCLES_P / 2
                            - 1);
                        wr_reg <= WR_PROGRAM;
                    end else begin
                        timer_reg <= timer_reg - 32'd1;
                    end
                end
                WR_PROGRAM: begin
                    if (timer_reg == 32'd0) begin
                        program_go_reg <= 1'b0;
                        wr_reg <= WR_IDLE;
                    end else begin
                        timer_reg <= timer_reg - 32'd1;
                    end
                end
                default: wr_reg <= WR_IDLE;
            endcase
        end
    end

    // storage array; erase sets all ones, program writes the byte
    always_ff @(posedge aclk) begin
        if (wr_reg == WR_ERASE && timer_reg == 32'd0) begin
            mem[wr_addr_reg] <= ERASED_BYTE;
        end else if (wr_reg == WR_PROGRAM && timer_reg == 32'd0) begin
            mem[wr_addr_reg] <= wr_byte_reg;
        end
    end

    // programmer port; blanked under code protection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prog_rdata <= '0;
        end else if (prog_rd_en) begin
            prog_rdata <= code_protect ? 8'h00 : mem[prog_addr];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt control register and gated done request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nv_done_irq_enable_reg <= 1'b0;
            global_irq_enable_reg <= 1'b0;
            nv_done_irq <= 1'b0;
        end else begin
            if (we_irq) begin
                nv_done_irq_enable_reg <= wbyte[IRQ_DONE_EN_BIT];
                global_irq_enable_reg <= wbyte[IRQ_GLOBAL_EN_BIT];
            end
            nv_done_irq <= nv_done_flag_reg && nv_done_irq_enable_reg
                && global_irq_enable_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // axi read channel; one answer at a time
    logic [7:0] rd_idx;
    logic [7:0] ctrl_view;
    assign rd_idx = s_axi_araddr[9:2];
    // upper control bits are unimplemented
    assign ctrl_view = {3'b000, nv_done_flag_reg, nv_abort_flag_reg,
        program_unlock_enable_reg, program_go_reg, fetch_go_reg};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else if (s_axi_arvalid && axo.arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= '0;
            if (s_axi_araddr[1:0] != 2'b00) begin
                rresp_reg <= RESP_SLVERR;
            end else if (rd_idx == NV_DATA_IDX) begin
                rdata_reg <= {24'h000000, nv_data_reg};
            end else if (rd_idx == NV_ADDR_IDX) begin
                rdata_reg <= {24'h000000, nv_addr_reg};
            end else if (rd_idx == NV_CTRL_IDX) begin
                rdata_reg <= {24'h000000, ctrl_view};
            end else if (rd_idx == NV_UNLOCK_IDX) begin
                rdata_reg <= 32'h00000000;
            end else if (rd_idx == NV_IRQCTL_IDX) begin
                rdata_reg <= {24'h000000, global_irq_enable_reg,
                    nv_done_irq_enable_reg, 6'h00};
            end else if (rd_idx == NV_RESET_IDX) begin
                rdata_reg <= 32'h00000000;
            end else begin
                rresp_reg <= RESP_SLVERR;
            end
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // port mapping
    assign s_axi_awready = axo.awready;
    assign s_axi_wready = axo.wready;
    assign s_axi_bvalid = axo.bvalid;
    assign s_axi_bresp = axo.bresp;
    assign s_axi_arready = axo.arready;
    assign s_axi_rvalid = axo.rvalid;
    assign s_axi_rdata = axo.rdata;
    assign s_axi_rresp = axo.rresp;
    assign write_busy = program_go_reg;

endmodule : nvacc_top

/* File: verification/nvacc_asserts.sv */
// concurrent checks on the nv storage controller ports
`timescale 1ns/1ns
module nvacc_asserts
    import nvacc_pkg::*;
#(
    parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    // programmer port and status
    input wire logic code_protect,
    input wire logic prog_rd_en,
    input wire logic [7:0] prog_rdata,
    input wire logic write_busy
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    // helpers: address of the read in flight, length of the busy run
    logic [ADDR_W-1:0] rd_addr;
    int busy_cnt;
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr <= s_axi_araddr;
        end
    end
    // counts busy cycles; the last busy sample sees WRITE_CYCLES_P - 1
    always_ff @(posedge aclk) begin
        if (!aresetn || !write_busy) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy_cnt + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // both parts are held one edge, then the response is issued
    property p_wr_answer; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
    property p_rd_answer; s_rd_taken |=> s_axi_rvalid; endproperty
    property p_ar_ready; s_axi_arready == !s_axi_rvalid; endproperty
    property p_aw_stall;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    property p_prog_block;
        prog_rd_en && code_protect |=> prog_rdata == 8'h00;
    endproperty
    property p_busy_min; $rose(write_busy) |-> write_busy [*3]; endproperty
    property p_busy_max; write_busy |-> busy_cnt < WRITE_CYCLES_P; endproperty
    property p_ctrl_zero;
        s_axi_rvalid && rd_addr == {NV_CTRL_IDX, 2'b00}
            |-> s_axi_rdata[31:5] == 27'h0;
    endproperty
    property p_unlock_zero;
        s_axi_rvalid && rd_addr == {NV_UNLOCK_IDX, 2'b00}
            |-> s_axi_rdata == 32'h0;
    endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("write response missing");
    a_rd_answer: assert property (p_rd_answer)
        else $error("read response missing");
    a_ar_ready: assert property (p_ar_ready)
        else $error("arready not the inverse of rvalid");
    a_aw_stall: assert property (p_aw_stall)
        else $error("write taken while response pending");
    a_prog_block: assert property (p_prog_block)
        else $error("programmer read not blanked");
    a_busy_min: assert property (p_busy_min)
        else $error("write cycle ended too early");
    a_busy_max: assert property (p_busy_max)
        else $error("write cycle too long");
    a_ctrl_zero: assert property (p_ctrl_zero)
        else $error("control upper bits not zero");
    a_unlock_zero: assert property (p_unlock_zero)
        else $error("unlock port read not zero");
endmodule : nvacc_asserts

/* File: verification/nvacc_top_tb.sv */
// self-checking bench for the nv storage controller
`timescale 1ns/1ns
module nvacc_top_tb;
    import nvacc_pkg::*;
    localparam int WCP = 8;
    localparam logic [9:0] A_DATA = {NV_DATA_IDX, 2'b00};
    localparam logic [9:0] A_ADDR = {NV_ADDR_IDX, 2'b00};
    localparam logic [9:0] A_CTRL = {NV_CTRL_IDX, 2'b00};
    localparam logic [9:0] A_KEY = {NV_UNLOCK_IDX, 2'b00};
    localparam logic [9:0] A_IRQ = {NV_IRQCTL_IDX, 2'b00};
    localparam logic [9:0] A_RST = {NV_RESET_IDX, 2'b00};
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, write_busy, nv_done_irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic code_protect = 1'b0, prog_rd_en = 1'b0;
    logic [NV_AW-1:0] prog_addr = '0;
    logic [7:0] prog_rdata;
    int n_fail = 0, tests_run = 0, cyc = 0;
    nvacc_top #(.WRITE_CYCLES_P(WCP)) nvacc_top_inst (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .code_protect, .prog_rd_en, .prog_addr, .prog_rdata,
        .write_busy, .nv_done_irq);
    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial forever #4 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks run %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one spare edge at the end so no strobe is driven twice in a step
    task automatic wr(input logic [9:0] a, input logic [7:0] d,
            input logic [1:0] er = RESP_OKAY);
        logic done;
        done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                done = 1'b1;
                s_axi_bready <= 1'b0;
                check(s_axi_bresp, er);
            end
        end
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [9:0] a, output logic [31:0] d,
            input logic [1:0] er = RESP_OKAY);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        check(s_axi_rresp, er);
        @(posedge aclk);
    endtask : rd
    task automatic rdc(input logic [9:0] a, input logic [31:0] m, e);
        logic [31:0] d;
        rd(a, d);
        check(d & m, e);
    endtask : rdc
    task automatic keys(input logic [7:0] k1, k2, c);
        wr(A_KEY, k1);
        wr(A_KEY, k2);
        wr(A_CTRL, c);
    endtask : keys
    task automatic start_wr(input logic [5:0] a, input logic [7:0] d);
        wr(A_DATA, d);
        wr(A_ADDR, {2'b00, a});
        wr(A_CTRL, 8'h04);
        keys(UNLOCK_KEY1, UNLOCK_KEY2, 8'h06);
        check(write_busy, 1'b1);
    endtask : start_wr
    // mid is written to control while the cycle runs
    task automatic nv_write(input logic [5:0] a, input logic [7:0] d, mid);
        int i;
        start_wr(a, d);
        wr(A_CTRL, mid);
        check(write_busy, 1'b1);
        for (i = 0; i < 4 * WCP && write_busy; i++) @(posedge aclk);
        check(write_busy, 1'b0);
        rdc(A_CTRL, 32'hff, 32'h10 | (mid & 8'h04));
    endtask : nv_write
    task automatic nv_read(input logic [5:0] a, input logic [7:0] e);
        wr(A_ADDR, {2'b00, a});
        wr(A_CTRL, 8'h01);
        rdc(A_DATA, 32'hffffffff, {24'h0, e});
        rdc(A_CTRL, 32'h01, 32'h0);
    endtask : nv_read
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [31:0] d;
        int b;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(A_CTRL, 32'hfffffff7, 32'h0);
        wr(A_ADDR, 8'h2a);
        rdc(A_ADDR, 32'hff, 32'h2a);
        wr(A_CTRL, 8'h00);
        keys(UNLOCK_KEY1, UNLOCK_KEY2, 8'h02);
        check(write_busy, 1'b0);
        wr(A_CTRL, 8'h04);
        keys(UNLOCK_KEY2, UNLOCK_KEY1, 8'h06);
        check(write_busy, 1'b0);
        keys(UNLOCK_KEY1, UNLOCK_KEY1, 8'h06);
        check(write_busy, 1'b0);
        nv_write(6'h3f, 8'h0f, 8'h04);
        nv_write(6'h3f, 8'hf0, 8'h00);
        nv_write(6'h00, 8'ha5, 8'h04);
        // done flag stays set until cleared, irq needs both enables
        wr(A_IRQ, 8'h40);
        check(nv_done_irq, 1'b0);
        wr(A_IRQ, 8'hc0);
        check(nv_done_irq, 1'b1);
        wr(A_CTRL, 8'h04);
        check(nv_done_irq, 1'b0);
        // interrupts masked before any further unlock sequence
        wr(A_IRQ, 8'h00);
        nv_read(6'h3f, 8'hf0);
        wr(A_ADDR, 8'h00);
        rdc(A_DATA, 32'hff, 32'hf0);
        for (b = 0; b < 2; b++) begin
            start_wr(6'h10, 8'h77);
            @(posedge aclk);
            wr(A_RST, 8'h01 << b);
            check(write_busy, 1'b0);
            rdc(A_CTRL, 32'h0a, 32'h08);
            wr(A_CTRL, 8'h00);
        end
        wr(10'h3fc, 8'h00, RESP_SLVERR);
        rd(10'h3fc, d, RESP_SLVERR);
        check(d, 32'h0);
        rdc(A_KEY, 32'hffffffff, 32'h0);
        prog_addr <= 6'h3f;
        prog_rd_en <= 1'b1;
        repeat (2) @(posedge aclk);
        check(prog_rdata, 8'hf0);
        code_protect <= 1'b1;
        repeat (2) @(posedge aclk);
        check(prog_rdata, 8'h00);
        nv_read(6'h00, 8'ha5);
        finish_test();
    end
endmodule : nvacc_top_tb
bind nvacc_top nvacc_asserts #(.WRITE_CYCLES_P(WRITE_CYCLES_P))
    nvacc_asserts_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .code_protect, .prog_rd_en, .prog_rdata, .write_busy);
